// ===== verilog/alarm_fet_pkg.sv
/*
 * package for the alarm mask and fet override register bank: register offsets,
 * field positions, reset values and the bundled types used by the bank.
 * assumes a 32-bit apb register bus and one 40 MHz device clock.
 */
`default_nettype none
package alarm_fet_pkg;
  // apb byte offsets
  localparam logic [7:0] MASK_OFS = 8'h00;
  localparam logic [7:0] FET_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RAW_OFS = 8'h0c;
  localparam logic [7:0] CFG_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h1c;
  // field positions
  localparam int CD_BIT = 1;
  localparam int CHARGE_FORCE_OFF_BIT = 3;
  localparam int DISCHARGE_FORCE_OFF_BIT = 2;
  localparam int CHARGE_FORCE_ON_BIT = 1;
  localparam int DISCHARGE_FORCE_ON_BIT = 0;
  localparam int OFF_PERMIT_BIT = 1;
  localparam int ON_PERMIT_BIT = 0;
  localparam logic [7:0] FET_WR_MASK = 8'h0f;
  // reset values
  localparam logic [15:0] DEFAULT_ALARM_MASK = 16'h0000;
  localparam logic [7:0] FET_RESET = 8'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;
  // interrupt event positions
  localparam int IRQ_ALERT_BIT = 0;
  localparam int IRQ_TOGGLE_BIT = 1;

  // charge and discharge driver pair
  typedef struct packed {
    logic chg;
    logic dsg;
  } fet_pair_s;

  typedef enum logic [1:0] {
    APB_IDLE,
    APB_ACCESS
  } apb_phase_e;
endpackage : alarm_fet_pkg
`default_nettype wire

// ===== verilog/alarm_mask_fet_override.sv
/*
 * alarm mask and fet override register bank: masks raw alarm flags into a
 * latched alarm status that drives an active-low alert pin, builds the charge
 * detector toggle flag, and applies host fet force-on/force-off overrides.
 * assumes raw flags and the debounced charge detector come from the same clock
 * domain, and an apb master on the register port.
 */
`timescale 1ns/1ps
`default_nettype none
module alarm_mask_fet_override
  import alarm_fet_pkg::*;
(
  input wire logic clk_in, // 40 MHz device clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  input wire logic [3:0] pstrb_in, // apb byte strobes
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error on unmapped address
  input wire logic [15:0] raw_alarm_in, // unlatched alarm flags, bit 1 read back but never latched
  input wire logic charge_detect_in, // debounced charge detector level
  input wire fet_pair_s protect_on_in, // normal protection turn-on request
  output fet_pair_s fet_drive_out, // final driver enables
  output logic alert_n_out, // alert pin, active low
  output logic irq_out // level interrupt
);

  logic [15:0] alarm_source_mask_q;
  logic [7:0] fet_host_override_q;
  logic [1:0] permit_q; // [1] off permit, [0] on permit
  logic [15:0] alarm_status_q;
  logic [15:0] alarm_status_d;
  logic cd_prev_q;
  logic charge_detector_change_flag_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [15:0] gated_src;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic cd_clr;
  logic host_off_override_permit;
  logic host_on_override_permit;
  fet_pair_s force_off;
  fet_pair_s force_on;
  fet_pair_s drive_d;
  apb_phase_e phase_q;

  // access phase decode; slave answers in the first access cycle
  assign addr_ok = (paddr_in == MASK_OFS) || (paddr_in == FET_OFS) || (paddr_in == STATUS_OFS) ||
                   (paddr_in == RAW_OFS) || (paddr_in == CFG_OFS) || (paddr_in == IRQ_STAT_OFS) ||
                   (paddr_in == IRQ_EN_OFS) || (paddr_in == IRQ_CLR_OFS);
  assign wr_en = psel_in && penable_in && pwrite_in && addr_ok && pready_out;
  assign rd_en = psel_in && penable_in && !pwrite_in;

  // phase tracker: pready high for exactly one access cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q <= APB_IDLE;
    end else if (psel_in && !penable_in) begin
      phase_q <= APB_ACCESS;
    end else begin
      phase_q <= APB_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !addr_ok;
    end
  end

  // read mux, registered at setup so data stands with pready
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      unique case (paddr_in)
        MASK_OFS: prdata_out <= {16'h0000, alarm_source_mask_q};
        FET_OFS: prdata_out <= {24'h000000, fet_host_override_q & FET_WR_MASK};
        STATUS_OFS: prdata_out <= {16'h0000, alarm_status_q};
        RAW_OFS: prdata_out <= {16'h0000, raw_alarm_in};
        CFG_OFS: prdata_out <= {30'h0, permit_q};
        IRQ_STAT_OFS: prdata_out <= {30'h0, irq_stat_q};
        IRQ_EN_OFS: prdata_out <= {30'h0, irq_en_q};
        default: prdata_out <= 32'h00000000;
      endcase
    end else begin
      prdata_out <= 32'h00000000;
    end
  end

  // alarm mask, loaded from the default at reset and rewritable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      alarm_source_mask_q <= DEFAULT_ALARM_MASK;
    end else if (wr_en && paddr_in == MASK_OFS) begin
      if (pstrb_in[0]) alarm_source_mask_q[7:0] <= pwdata_in[7:0];
      if (pstrb_in[1]) alarm_source_mask_q[15:8] <= pwdata_in[15:8];
    end
  end

  // fet override register; upper nibble never stored
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fet_host_override_q <= FET_RESET;
    end else if (wr_en && paddr_in == FET_OFS && pstrb_in[0]) begin
      fet_host_override_q <= pwdata_in[7:0] & FET_WR_MASK;
    end
  end

  // configuration permission bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      permit_q <= CFG_RESET;
    end else if (wr_en && paddr_in == CFG_OFS && pstrb_in[0]) begin
      permit_q <= pwdata_in[1:0];
    end
  end

  // status bit 1 clear strobe; also keeps the stale flag from re-setting status
  assign cd_clr = wr_en && (paddr_in == STATUS_OFS) && pstrb_in[0] && pwdata_in[CD_BIT];

  // charge detector toggle flag, cleared by writing one to status bit 1
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cd_prev_q <= 1'b0;
      charge_detector_change_flag_q <= 1'b0;
    end else begin
      cd_prev_q <= charge_detect_in;
      if (charge_detect_in != cd_prev_q) begin
        charge_detector_change_flag_q <= 1'b1;
      end else if (cd_clr) begin
        charge_detector_change_flag_q <= 1'b0;
      end
    end
  end

  // gate sources by mask; bit 1 takes the toggle flag, not the raw level
  generate
    for (genvar i = 0; i < 16; i++) begin : g_gate
      if (i == CD_BIT) begin : g_cd
        assign gated_src[i] = alarm_source_mask_q[i] & charge_detector_change_flag_q & ~cd_clr;
      end else begin : g_raw
        assign gated_src[i] = alarm_source_mask_q[i] & raw_alarm_in[i];
      end
    end
  endgenerate

  // latched status: set wins over write-one-to-clear
  always_comb begin
    alarm_status_d = alarm_status_q;
    if (wr_en && paddr_in == STATUS_OFS) begin
      alarm_status_d = alarm_status_q & ~pwdata_in[15:0];
    end
    alarm_status_d = alarm_status_d | gated_src;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      alarm_status_q <= 16'h0000;
    end else begin
      alarm_status_q <= alarm_status_d;
    end
  end

  // alert pin follows the latched status
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      alert_n_out <= 1'b1;
    end else begin
      alert_n_out <= ~(|alarm_status_d);
    end
  end

  // override resolution
  assign host_off_override_permit = permit_q[OFF_PERMIT_BIT];
  assign host_on_override_permit = permit_q[ON_PERMIT_BIT];
  assign force_off.chg = host_off_override_permit & fet_host_override_q[CHARGE_FORCE_OFF_BIT];
  assign force_off.dsg = host_off_override_permit & fet_host_override_q[DISCHARGE_FORCE_OFF_BIT];
  assign force_on.chg = host_on_override_permit & fet_host_override_q[CHARGE_FORCE_ON_BIT];
  assign force_on.dsg = host_on_override_permit & fet_host_override_q[DISCHARGE_FORCE_ON_BIT];

  always_comb begin
    drive_d.chg = !force_off.chg && (force_on.chg || protect_on_in.chg);
    drive_d.dsg = !force_off.dsg && (force_on.dsg || protect_on_in.dsg);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fet_drive_out <= '0;
    end else begin
      fet_drive_out <= drive_d;
    end
  end

  // interrupt: sticky events, enable, write-one clear; set beats clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_stat_q <= 2'h0;
      irq_en_q <= IRQ_EN_RESET;
    end else begin
      if (wr_en && paddr_in == IRQ_EN_OFS && pstrb_in[0]) begin
        irq_en_q <= pwdata_in[1:0];
      end
      for (int b = 0; b < 2; b++) begin
        if ((b == IRQ_ALERT_BIT && |gated_src) || (b == IRQ_TOGGLE_BIT && charge_detect_in != cd_prev_q)) begin
          irq_stat_q[b] <= 1'b1;
        end else if (wr_en && paddr_in == IRQ_CLR_OFS && pstrb_in[0] && pwdata_in[b]) begin
          irq_stat_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_q & irq_en_q);
    end
  end

  // checks: named steps of the multi-cycle behaviours
  sequence s_cd_change;
    charge_detect_in != cd_prev_q;
  endsequence

  sequence s_toggle_armed;
    alarm_source_mask_q[CD_BIT] && !cd_clr;
  endsequence

  sequence s_setup_phase;
    psel_in && !penable_in;
  endsequence

  sequence s_access_phase;
    psel_in && penable_in;
  endsequence

  // masking into the latched status
  a_masked_raw_blocked: assert property (@(posedge clk_in) disable iff (rst_in)
    (!alarm_source_mask_q[15] && !alarm_status_q[15] && !(wr_en && paddr_in == MASK_OFS))
    |=> !alarm_status_q[15]) else $error("masked flag reached status");
  a_enabled_raw_latched: assert property (@(posedge clk_in) disable iff (rst_in)
    (alarm_source_mask_q[15] && raw_alarm_in[15]) |=> alarm_status_q[15])
    else $error("enabled flag not latched");
  a_status_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    (alarm_status_q[15] && !(wr_en && paddr_in == STATUS_OFS)) |=> alarm_status_q[15])
    else $error("latched flag dropped");
  a_cd_raw_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    (!charge_detector_change_flag_q && !alarm_status_q[CD_BIT]) |=> !alarm_status_q[CD_BIT])
    else $error("raw detector level reached status");

  // detector toggle flag
  a_toggle_flag_set: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cd_change |=> charge_detector_change_flag_q)
    else $error("toggle flag missed");
  a_toggle_into_status: assert property (@(posedge clk_in) disable iff (rst_in)
    (alarm_source_mask_q[CD_BIT] && charge_detector_change_flag_q && !cd_clr) |=> alarm_status_q[CD_BIT])
    else $error("toggle not in status");
  a_toggle_to_alert: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cd_change ##1 s_toggle_armed |=> (alarm_status_q[CD_BIT] && !alert_n_out))
    else $error("detector change did not raise alert");
  a_toggle_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (cd_clr && charge_detect_in == cd_prev_q) |=> !charge_detector_change_flag_q)
    else $error("toggle flag not cleared");

  // alert pin
  a_alert_follows_status: assert property (@(posedge clk_in) disable iff (rst_in)
    (alarm_status_q != 16'h0000) |-> !alert_n_out)
    else $error("alert high with status set");
  a_alert_idle_high: assert property (@(posedge clk_in) disable iff (rst_in)
    ($past(alarm_status_d) == 16'h0000) |-> alert_n_out)
    else $error("alert low with no status");
  a_alert_mask_only: assert property (@(posedge clk_in) disable iff (rst_in)
    (alarm_source_mask_q == 16'h0000 && alarm_status_q == 16'h0000) |=> alert_n_out)
    else $error("masked flags moved the alert pin");

  // fet overrides
  a_charge_force_off_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    (permit_q[OFF_PERMIT_BIT] && fet_host_override_q[CHARGE_FORCE_OFF_BIT]) |=> !fet_drive_out.chg)
    else $error("charge not forced off");
  a_discharge_force_off_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    (permit_q[OFF_PERMIT_BIT] && fet_host_override_q[DISCHARGE_FORCE_OFF_BIT]) |=> !fet_drive_out.dsg)
    else $error("discharge not forced off");
  a_charge_force_on_forced: assert property (@(posedge clk_in) disable iff (rst_in)
    (permit_q == 2'h1 && fet_host_override_q[CHARGE_FORCE_ON_BIT]) |=> fet_drive_out.chg)
    else $error("charge not forced on");
  a_discharge_force_on_forced: assert property (@(posedge clk_in) disable iff (rst_in)
    (permit_q == 2'h1 && fet_host_override_q[DISCHARGE_FORCE_ON_BIT]) |=> fet_drive_out.dsg)
    else $error("discharge not forced on");
  a_off_needs_permit: assert property (@(posedge clk_in) disable iff (rst_in)
    (permit_q == 2'h0 && protect_on_in.chg) |=> fet_drive_out.chg)
    else $error("off override without permission");
  a_discharge_force_off_permit: assert property (@(posedge clk_in) disable iff (rst_in)
    (permit_q == 2'h0 && protect_on_in.dsg) |=> fet_drive_out.dsg)
    else $error("discharge off without permission");
  a_on_needs_permit: assert property (@(posedge clk_in) disable iff (rst_in)
    (!permit_q[ON_PERMIT_BIT] && !protect_on_in.chg && !protect_on_in.dsg) |=> (fet_drive_out == '0))
    else $error("on override without permission");
  a_zero_override_normal: assert property (@(posedge clk_in) disable iff (rst_in)
    (fet_host_override_q == 8'h00) |=> (fet_drive_out == $past(protect_on_in)))
    else $error("driver not under normal control");
  a_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    fet_host_override_q[7:4] == 4'h0)
    else $error("reserved fet bits stored");
  a_mask_reset_value: assert property (@(posedge clk_in)
    rst_in |=> alarm_source_mask_q == DEFAULT_ALARM_MASK)
    else $error("mask reset wrong");

  // register port and interrupt
  a_phase_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
    (phase_q == APB_ACCESS) |=> (phase_q == APB_IDLE && !pready_out))
    else $error("ready held past one cycle");
  a_ready_in_access: assert property (@(posedge clk_in) disable iff (rst_in)
    s_setup_phase ##1 s_access_phase |-> pready_out)
    else $error("ready missing in access");
  a_err_with_ready: assert property (@(posedge clk_in) disable iff (rst_in)
    pslverr_out |-> pready_out)
    else $error("error without ready");
  a_read_idle_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    !pready_out |-> (prdata_out == 32'h00000000))
    else $error("read data outside access");
  a_write_reads_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (pready_out && !rd_en) |-> (prdata_out == 32'h00000000))
    else $error("read data during write");
  a_irq_follows: assert property (@(posedge clk_in) disable iff (rst_in)
    ((irq_stat_q & irq_en_q) != 2'h0) |=> irq_out)
    else $error("interrupt missing");
  a_irq_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    ((irq_stat_q & irq_en_q) == 2'h0) |=> !irq_out)
    else $error("interrupt without enabled event");

endmodule : alarm_mask_fet_override
`default_nettype wire

// ===== tb/apb_host_model.sv
/*
 * apb host model: the microcontroller side of the register port, issuing
 * one transfer at a time through the xfer task.
 * assumes the slave raises pready for at least one rising edge per access.
 */
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input wire logic clk_in, // bus clock
  input wire logic [31:0] prdata_in, // read data from slave
  input wire logic pready_in, // slave ready
  input wire logic pslverr_in, // slave error
  output logic psel_out, // select
  output logic penable_out, // enable
  output logic pwrite_out, // direction
  output logic [7:0] paddr_out, // byte address
  output logic [31:0] pwdata_out, // write data
  output logic [3:0] pstrb_out // byte strobes
);
  // idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
    pstrb_out = 4'h0;
  end

  // one transfer: setup, access held until pready, then release with scrambled lines
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    pstrb_out <= 4'hf;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a; // released lines must not keep the last value
    pwdata_out <= ~d;
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// ===== tb/alarm_mask_fet_override_bench.sv
/*
 * self-checking bench for the alarm mask and fet override bank: random masks
 * and flags with corner cases, every override setting swept, through the apb host model.
 * assumes the package offsets; every transfer waits for pready, the watchdog ends a hang.
 */
`timescale 1ns/1ps
`default_nettype none
module alarm_mask_fet_override_bench;
  import alarm_fet_pkg::*;
  logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, er, cdet, alert_n, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] raw, m, r;
  fet_pair_s prot, drive, e;
  int err_count, checked;

  // clock, 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  apb_host_model i_host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata), .pstrb_out(pstrb));

  alarm_mask_fet_override i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .raw_alarm_in(raw), .charge_detect_in(cdet),
    .protect_on_in(prot), .fet_drive_out(drive), .alert_n_out(alert_n), .irq_out(irq));

  // expected driver enables: force-off wins, force-on needs its permit
  function automatic fet_pair_s fet_exp(logic [1:0] c, logic [3:0] f, fet_pair_s p);
    fet_pair_s q;
    q.chg = !(c[1] & f[3]) & ((c[0] & f[1]) | p.chg);
    q.dsg = !(c[1] & f[2]) & ((c[0] & f[0]) | p.dsg);
    return q;
  endfunction : fet_exp

  // compare and count
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdr(logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, rd, er);
  endtask : rdr

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog
  initial begin
    #(25 * 20000);
    err_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    rst_in = 1'b1;
    raw = 16'h0;
    cdet = 1'b0;
    prot = '0;
    err_count = 0;
    checked = 0;
    void'($urandom(32'ha1dd));
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rdr(MASK_OFS);
    chk("mask reset", rd, {16'h0, DEFAULT_ALARM_MASK});
    rdr(FET_OFS);
    chk("fet reset", rd, 32'h0);
    chk("alert idle", {31'h0, alert_n}, 32'h1);
    chk("drive idle", {30'h0, drive}, 32'h0);
    rdr(8'h20);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      r = (i < 2) ? 16'hffff : 16'($urandom);
      wr(MASK_OFS, {16'h0, m});
      @(posedge clk_in);
      raw <= r;
      @(posedge clk_in);
      raw <= 16'h0;
      repeat (2) @(posedge clk_in);
      rdr(STATUS_OFS);
      chk("status", rd, {16'h0, r & m & 16'hfffd});
      chk("alert", {31'h0, alert_n}, {31'h0, (r & m & 16'hfffd) == 16'h0});
      wr(STATUS_OFS, 32'hffff);
      @(posedge clk_in);
      #1 chk("alert cleared", {31'h0, alert_n}, 32'h1);
    end
    $display("test mask latching done");
    wr(MASK_OFS, 32'h2);
    @(posedge clk_in);
    raw <= 16'h2;
    repeat (3) @(posedge clk_in);
    rdr(STATUS_OFS);
    chk("raw bit1 ignored", rd, 32'h0);
    rdr(RAW_OFS);
    chk("raw readback", rd, 32'h2);
    cdet <= ~cdet;
    repeat (3) @(posedge clk_in);
    rdr(STATUS_OFS);
    chk("toggle set", rd, 32'h2);
    wr(STATUS_OFS, 32'h2);
    wr(MASK_OFS, 32'h0);
    cdet <= ~cdet;
    raw <= 16'h0;
    repeat (3) @(posedge clk_in);
    rdr(STATUS_OFS);
    chk("toggle masked", rd, 32'h0);
    $display("test detector toggle done");
    wr(IRQ_EN_OFS, 32'h0);
    wr(IRQ_CLR_OFS, 32'h3);
    rdr(IRQ_STAT_OFS);
    chk("irq stat cleared", rd, 32'h0);
    wr(MASK_OFS, 32'h8000);
    @(posedge clk_in);
    raw <= 16'h8000;
    @(posedge clk_in);
    raw <= 16'h0;
    repeat (2) @(posedge clk_in);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdr(IRQ_STAT_OFS);
    chk("irq status", rd & 32'h1, 32'h1);
    wr(IRQ_EN_OFS, 32'h1);
    rdr(IRQ_EN_OFS);
    chk("irq enable", rd, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(STATUS_OFS, 32'hffff);
    wr(IRQ_CLR_OFS, 32'h3);
    repeat (2) @(posedge clk_in);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
    for (int c = 0; c < 4; c++) begin
      for (int f = 0; f < 16; f++) begin
        wr(CFG_OFS, 32'(c));
        wr(FET_OFS, ($urandom & 32'hfffffff0) | 32'(f));
        rdr(FET_OFS);
        chk("fet readback", rd, 32'(f));
        @(posedge clk_in);
        prot <= fet_pair_s'(2'($urandom));
        repeat (3) @(posedge clk_in);
        e = fet_exp(2'(c), 4'(f), prot);
        chk("fet drive", {30'h0, drive}, {30'h0, e});
      end
    end
    rdr(CFG_OFS);
    chk("cfg readback", rd, 32'h3);
    $display("test fet override done");
    tally_and_finish();
  end
endmodule : alarm_mask_fet_override_bench
`default_nettype wire
